// ---- src/gop_core.sv ----
// Function
// - close closes open or opening gate
// - stop halts motion at any time except during an emergency run or the reverse back-off
// - single input toggles, reverses while moving
// - open-stop-close option stops moving gate
// - emergency fully opens, lockout code 04, stop releases
// - obstruction stops, reverses briefly, stops, no autoclose
// - second obstruction before limit means entrapment alarm
// - close obstruction mirrors open obstruction
// - reverse while closing opens fully unless partial stop is set, autoclose later
// - loops and open input alias buttons
// - shadow loop holds gate, closes on release
// - dashes then version, one second each
// - last position code shown up to minute
// - reverse delay countdown shown in seconds
// - run time in seconds while moving
// - entrapment code 00, beeper on, stop/reset clears
// - reset control never starts motion
// - link failure blinks 1 Hz, code 03, minute alarm
// - transmitter trouble: fast beeps, run tail, idle chirp
// - max run time is entrapment, then double beeps
// - power fail 05, low ac 07, until good
// - motor mismatch 11, motor failure 12
// - held open overrides partial stop, suspends autoclose
// Purpose: gate operator command and error state machine
// Assumes: inputs raw, limits and faults are levels from the motor side
// Notes: input bit map: 0 open 1 close 2 stop 3 single 4 emerg 5 obs_open 6 obs_close
// 7 reverse 8 rev_loop 9 open_loop 10 shadow 11 reset 12 lim_open 13 lim_close
// 14 open_in 15 trouble
`include "gop_regs.svh"
module gop_core #(
    parameter int CLK_HZ = `GOP_CLK_HZ,
    parameter int REV_CYC = `GOP_REV_CYC,
    parameter int ACLO_S = 30,
    parameter int PART_S = 10,
    parameter int MAXRUN_S = 60,
    parameter int PRE_S = 2
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [15:0] raw_in,
    input wire logic link_ok,
    input wire logic batt_good,
    input wire logic ac_good,
    input wire logic motor_mismatch,
    input wire logic motor_fail,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic motor_open,
    output logic motor_close,
    output logic [7:0] disp_code,
    output logic beeper,
    output logic link_led,
    output logic maxrun_led
);
    import gop_pkg::*;
    initial begin
        // reverse must end before the second tick restarts its count
        if (CLK_HZ < 2 || REV_CYC < 1 || REV_CYC > CLK_HZ * `GOP_SEC_S || MAXRUN_S < 1 ||
            ACLO_S < 1) $error("bad params");
    end
    localparam int SECC = CLK_HZ * `GOP_SEC_S;
    gop_sync_if sif();
    gop_debounce #(.N(GOP_NIN)) u_db (.clk(clk), .rstn(rstn), .raw(raw_in), .out(sif));
    logic [7:0] cfg, sw_cmd, run_s_q;
    logic [31:0] stat;
    gop_apb u_apb (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cfg(cfg), .sw_cmd(sw_cmd), .stat(stat),
        .disp(disp_code), .runt({8'h00, run_s_q}));
    gop_in_t lv, rs;
    assign lv = sif.lvl;
    assign rs = sif.rise | {8'h00, sw_cmd};
    wire c_open = rs[0] | rs[9] | rs[14];
    wire h_open = lv[0] | lv[9] | lv[14];
    wire c_close = rs[1];
    wire c_stop = rs[2] | lv[2];
    wire c_single = rs[3];
    wire c_emerg = rs[4] | lv[4];
    wire c_rev = lv[7] | lv[8];
    wire shadow = lv[10];
    wire c_reset = rs[11];
    wire lim_o = lv[12];
    wire lim_c = lv[13];
    wire trouble = lv[15];
    wire osc = cfg[`GOP_CFG_OSC];
    gop_state_e st_q, st_d;
    logic [31:0] tick_q;
    logic [7:0] sec_q, ac_s_q, show_s_q;
    // nine bits: the trouble tail outlasts 255 s
    logic [8:0] tail_s_q;
    logic dir_open_q, obs_once_q, aclo_dis_q, maxrun_q, emerg_run_q;
    logic [1:0] pu_q;
    logic [7:0] code_q;
    wire sec_tick = tick_q == 32'(SECC - 1);
    wire [31:0] rev_lim = 32'(REV_CYC - 1);
    wire obs_hit = (st_q == GOP_OPENING && lv[5]) || (st_q == GOP_CLOSING && lv[6]);
    wire moving = st_q == GOP_OPENING || st_q == GOP_CLOSING;
    wire faults = !batt_good || !ac_good || motor_mismatch || motor_fail;
    wire link_bad = cfg[`GOP_CFG_LINKEN] && !link_ok;
    wire part_stop = cfg[`GOP_CFG_PART] && st_q == GOP_OPENING && !emerg_run_q &&
        !h_open && run_s_q >= 8'(PART_S);
    wire aclo_go = cfg[`GOP_CFG_ACLO] && !aclo_dis_q && !h_open && !c_rev && !shadow &&
        lim_o && ac_s_q >= 8'(ACLO_S);
    always_comb begin
        st_d = st_q;
        case (st_q)
            GOP_POWERUP: if (pu_q == 2'd2) st_d = GOP_IDLE;
            GOP_IDLE: begin
                if (c_emerg) st_d = GOP_OPENING;
                else if (faults) st_d = GOP_LOCK_FAULT;
                else if (link_bad) st_d = GOP_IDLE;
                else if (shadow) st_d = GOP_IDLE;
                else if (c_open || (c_rev && !lim_o)) st_d = GOP_OPENING;
                else if ((c_close || aclo_go) && !lim_c) st_d = GOP_CLOSING;
                else if (c_single) st_d = lim_c ? GOP_OPENING : GOP_CLOSING;
            end
            GOP_OPENING, GOP_CLOSING: begin
                if (c_stop && !emerg_run_q) st_d = GOP_IDLE;
                else if (faults && !emerg_run_q) st_d = GOP_LOCK_FAULT;
                else if (run_s_q >= 8'(MAXRUN_S)) st_d = GOP_LOCK_ENT;
                else if (obs_hit && !emerg_run_q) st_d = obs_once_q ? GOP_LOCK_ENT :
                    GOP_REVERSE;
                else if (st_q == GOP_OPENING && lim_o) st_d = emerg_run_q ? GOP_LOCK_EMRG :
                    GOP_IDLE;
                else if (st_q == GOP_CLOSING && lim_c) st_d = GOP_IDLE;
                else if (part_stop) st_d = GOP_IDLE;
                else if (st_q == GOP_CLOSING && (c_emerg || c_rev || c_open))
                    st_d = GOP_OPENING;
                // an emergency run ignores user reversal until the open limit
                else if (c_single && !emerg_run_q) st_d = osc ? GOP_IDLE :
                    (st_q == GOP_OPENING ? GOP_CLOSING : GOP_OPENING);
                else if (st_q == GOP_OPENING && c_close && !emerg_run_q)
                    st_d = GOP_CLOSING;
            end
            GOP_REVERSE: if (tick_q == rev_lim) st_d = GOP_IDLE;
            GOP_LOCK_ENT: if (c_stop || c_reset) st_d = GOP_IDLE;
            GOP_LOCK_EMRG: if (c_stop && !lv[4]) st_d = GOP_IDLE;
            GOP_LOCK_FAULT: if (!faults) st_d = GOP_IDLE;
            default: st_d = GOP_IDLE;
        endcase
    end
    wire start = st_d != st_q && (st_d == GOP_OPENING || st_d == GOP_CLOSING);
    wire tick_rst = start || st_d != st_q || sec_tick;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= GOP_POWERUP;
            tick_q <= 32'h00000000;
            pu_q <= 2'd0;
        end else begin
            st_q <= st_d;
            tick_q <= tick_rst ? 32'h00000000 : tick_q + 32'h00000001;
            if (st_q == GOP_POWERUP && sec_tick) pu_q <= pu_q + 2'd1;
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            run_s_q <= 8'h00;
            ac_s_q <= 8'h00;
            show_s_q <= 8'h00;
            tail_s_q <= 9'h000;
            sec_q <= 8'h00;
        end else begin
            run_s_q <= start ? 8'h00 : (moving && sec_tick) ? run_s_q + 8'h01 : run_s_q;
            ac_s_q <= (st_q != GOP_IDLE || c_rev || h_open) ? 8'h00 :
                (sec_tick && ac_s_q != 8'hFF) ? ac_s_q + 8'h01 : ac_s_q;
            show_s_q <= (st_d != st_q) ? 8'h00 :
                (sec_tick && show_s_q != 8'hFF) ? show_s_q + 8'h01 : show_s_q;
            tail_s_q <= moving ? 9'h000 :
                (sec_tick && tail_s_q != 9'h1FF) ? tail_s_q + 9'h001 : tail_s_q;
            sec_q <= sec_tick ? sec_q + 8'h01 : sec_q;
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dir_open_q <= 1'b0;
            obs_once_q <= 1'b0;
            aclo_dis_q <= 1'b0;
            maxrun_q <= 1'b0;
            emerg_run_q <= 1'b0;
            code_q <= `GOP_CODE_DASH;
        end else begin
            if (st_q == GOP_REVERSE) dir_open_q <= dir_open_q;
            else if (moving) dir_open_q <= st_q == GOP_OPENING;
            if (obs_hit && st_d == GOP_REVERSE) obs_once_q <= 1'b1;
            else if (lim_o || lim_c || st_q == GOP_LOCK_ENT) obs_once_q <= 1'b0;
            if (obs_hit) aclo_dis_q <= 1'b1;
            else if (start) aclo_dis_q <= 1'b0;
            if (moving && st_d == GOP_LOCK_ENT && !obs_hit) maxrun_q <= 1'b1;
            else if (start) maxrun_q <= 1'b0;
            if (c_emerg && st_d == GOP_OPENING) emerg_run_q <= 1'b1;
            else if (st_q == GOP_LOCK_EMRG || st_d == GOP_IDLE) emerg_run_q <= 1'b0;
            if (st_q == GOP_LOCK_ENT && st_d != st_q) code_q <= `GOP_CODE_ENT;
            else if (st_d == GOP_IDLE && st_q != GOP_IDLE && st_q != GOP_POWERUP)
                code_q <= lim_o ? `GOP_CODE_FOP : lim_c ? `GOP_CODE_FCL : `GOP_CODE_STOP;
        end
    end
    // motor held off in every lock; reverse runs opposite for the brief back-off
    wire rev_open = st_q == GOP_REVERSE && !dir_open_q;
    wire rev_close = st_q == GOP_REVERSE && dir_open_q;
    logic mo_q, mc_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mo_q <= 1'b0;
            mc_q <= 1'b0;
        end else begin
            mo_q <= st_d == GOP_OPENING || (st_d == GOP_REVERSE && st_q == GOP_CLOSING) ||
                (st_d == GOP_REVERSE && st_q == GOP_REVERSE && rev_open);
            mc_q <= st_d == GOP_CLOSING || (st_d == GOP_REVERSE && st_q == GOP_OPENING) ||
                (st_d == GOP_REVERSE && st_q == GOP_REVERSE && rev_close);
        end
    end
    assign motor_open = mo_q;
    assign motor_close = mc_q;
    wire [7:0] rev_left = 8'((REV_CYC - 1 - int'(tick_q)) / SECC + 1);
    wire [7:0] code_fault = motor_fail ? `GOP_CODE_MFL : motor_mismatch ? `GOP_CODE_MIS :
        !batt_good ? `GOP_CODE_PWR : `GOP_CODE_ACL;
    wire [7:0] last_code = (show_s_q < 8'(`GOP_MIN_S)) ? code_q : `GOP_CODE_IDLE;
    logic [7:0] disp_d, disp_q;
    always_comb begin
        case (st_q)
            GOP_POWERUP: disp_d = pu_q == 2'd0 ? `GOP_CODE_DASH : `GOP_CODE_VER;
            GOP_OPENING, GOP_CLOSING: disp_d = run_s_q;
            GOP_REVERSE: disp_d = rev_left;
            GOP_LOCK_ENT: disp_d = maxrun_q ? (dir_open_q ? `GOP_CODE_RUNO : `GOP_CODE_RUNC) :
                `GOP_CODE_ENT;
            GOP_LOCK_EMRG: disp_d = `GOP_CODE_EMRG;
            GOP_LOCK_FAULT: disp_d = code_fault;
            GOP_IDLE: disp_d = link_bad ? `GOP_CODE_LINK : last_code;
            default: disp_d = `GOP_CODE_IDLE;
        endcase
    end
    wire half = tick_q < 32'(SECC / 2);
    wire quart = tick_q < 32'(SECC / 4) ||
        (tick_q >= 32'(SECC / 2) && tick_q < 32'(SECC * 3 / 4));
    wire beep_run = moving && (trouble ? quart : half);
    wire beep_tail = trouble && st_q == GOP_IDLE && tail_s_q < 9'(`GOP_TRBL_RUN_S) &&
        quart;
    wire chirp = trouble && st_q == GOP_IDLE && (sec_q % 8'(`GOP_FIVE_S)) == 8'h00 &&
        tick_q < 32'(SECC / 16);
    wire dbl = maxrun_q && st_q == GOP_IDLE && (sec_q % 8'(`GOP_FIVE_S)) == 8'h00 &&
        (tick_q < 32'(SECC / 8) || (tick_q >= 32'(SECC / 4) &&
        tick_q < 32'(SECC * 3 / 8)));
    wire link_alarm = link_bad && show_s_q < 8'(`GOP_MIN_S);
    logic beep_q, led_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            disp_q <= `GOP_CODE_DASH;
            beep_q <= 1'b0;
            led_q <= 1'b0;
        end else begin
            disp_q <= disp_d;
            beep_q <= st_q == GOP_LOCK_ENT || link_alarm || beep_run || beep_tail ||
                chirp || dbl;
            led_q <= link_bad && half;
        end
    end
    assign disp_code = disp_q;
    assign beeper = beep_q;
    assign link_led = led_q;
    assign maxrun_led = maxrun_q;
    assign stat = {24'h000000, maxrun_q, obs_once_q, aclo_dis_q, emerg_run_q, 4'(st_q)};
    ent_no_motor_a: assert property (@(posedge clk) disable iff (!rstn)
        st_q == GOP_LOCK_ENT |=> !motor_open && !motor_close) else $error("motor in lock");
    stop_halts_a: assert property (@(posedge clk) disable iff (!rstn)
        moving && c_stop && !emerg_run_q |=> st_q == GOP_IDLE) else $error("stop ignored");
    reset_nostart_a: assert property (@(posedge clk) disable iff (!rstn)
        st_q == GOP_LOCK_ENT && c_reset |=> st_q == GOP_IDLE) else $error("reset lock");
    second_obs_a: assert property (@(posedge clk) disable iff (!rstn)
        obs_hit && obs_once_q && !emerg_run_q && !c_stop && !faults &&
        run_s_q < 8'(MAXRUN_S) |=> st_q == GOP_LOCK_ENT) else $error("no entrapment");
    emerg_code_a: assert property (@(posedge clk) disable iff (!rstn)
        st_q == GOP_LOCK_EMRG |=> disp_code == `GOP_CODE_EMRG) else $error("code 04");
    ent_beep_a: assert property (@(posedge clk) disable iff (!rstn)
        st_q == GOP_LOCK_ENT |=> beeper) else $error("beeper off in lock");
    fault_lock_a: assert property (@(posedge clk) disable iff (!rstn)
        st_q == GOP_IDLE && faults && !c_emerg |=> st_q == GOP_LOCK_FAULT)
        else $error("fault not locked");
    rev_motor_a: assert property (@(posedge clk) disable iff (!rstn)
        st_q == GOP_REVERSE |-> motor_close == dir_open_q && motor_open == !dir_open_q)
        else $error("reverse motor");
    emerg_open_a: assert property (@(posedge clk) disable iff (!rstn)
        st_q == GOP_IDLE && c_emerg |=> st_q == GOP_OPENING && motor_open)
        else $error("emergency not opening");
    fault_code_a: assert property (@(posedge clk) disable iff (!rstn)
        st_q == GOP_LOCK_FAULT && motor_fail |=> disp_code == `GOP_CODE_MFL)
        else $error("code 12");
    maxrun_lock_a: assert property (@(posedge clk) disable iff (!rstn)
        moving && run_s_q >= 8'(MAXRUN_S) && !c_stop && !faults && !obs_hit
        |=> st_q == GOP_LOCK_ENT && maxrun_led) else $error("max run missed");
    link_idle_a: assert property (@(posedge clk) disable iff (!rstn)
        st_q == GOP_IDLE && link_bad && !c_emerg && !faults |=> st_q == GOP_IDLE)
        else $error("link fail moved");
    cv_open: cover property (@(posedge clk) st_q == GOP_IDLE ##1 st_q == GOP_OPENING);
    cv_rev: cover property (@(posedge clk) st_q == GOP_REVERSE);
    cv_ent: cover property (@(posedge clk) st_q == GOP_LOCK_ENT);
    cv_emrg: cover property (@(posedge clk) st_q == GOP_LOCK_EMRG);
endmodule

// ---- src/gop_regs.svh ----
// Purpose: constants for the gate operator control block
// Assumes: 125 MHz clock
// Notes: register offsets are byte addresses on the apb word bus
`ifndef GOP_REGS_SVH
`define GOP_REGS_SVH
`define GOP_CLK_HZ 125000000
`define GOP_SEC_S 1
`define GOP_MIN_S 60
`define GOP_FIVE_S 5
`define GOP_TRBL_RUN_S 300
`define GOP_DBNC_CYC 16
`define GOP_REV_CYC 62500000
`define GOP_OFF_CTRL 12'h000
`define GOP_OFF_CFG 12'h004
`define GOP_OFF_STAT 12'h008
`define GOP_OFF_DISP 12'h00C
`define GOP_OFF_RUNT 12'h010
`define GOP_CODE_ENT 8'h00
`define GOP_CODE_RUNO 8'h01
`define GOP_CODE_RUNC 8'h02
`define GOP_CODE_LINK 8'h03
`define GOP_CODE_EMRG 8'h04
`define GOP_CODE_PWR 8'h05
`define GOP_CODE_ACL 8'h07
`define GOP_CODE_MIS 8'h11
`define GOP_CODE_MFL 8'h12
`define GOP_CODE_DASH 8'hDD
`define GOP_CODE_VER 8'hA1
`define GOP_CODE_STOP 8'h5E
`define GOP_CODE_FCL 8'hFC
`define GOP_CODE_FOP 8'hF0
`define GOP_CODE_IDLE 8'hEE
`define GOP_CFG_ACLO 0
`define GOP_CFG_OSC 1
`define GOP_CFG_PART 2
`define GOP_CFG_LINKEN 3
`endif

// ---- src/gop_pkg.sv ----
// Purpose: types for the gate operator control block
// Assumes: nothing
// Notes: inputs bundle order is fixed
package gop_pkg;
    typedef enum logic [3:0] {
        GOP_POWERUP, GOP_IDLE, GOP_OPENING, GOP_CLOSING, GOP_REVERSE,
        GOP_LOCK_ENT, GOP_LOCK_EMRG, GOP_LOCK_FAULT
    } gop_state_e;
    localparam int GOP_NIN = 16;
    typedef logic [GOP_NIN-1:0] gop_in_t;
endpackage

// ---- src/gop_sync_if.sv ----
// Purpose: carries the cleaned input bundle between the filter and the core
// Assumes: single clock
// Notes: none
interface gop_sync_if;
    import gop_pkg::*;
    gop_in_t lvl;
    gop_in_t rise;
    modport src(output lvl, output rise);
    modport dst(input lvl, input rise);
endinterface

// ---- src/gop_debounce.sv ----
// Purpose: synchronise and debounce all control inputs
// Assumes: inputs are raw contacts
// Notes: a bit changes only after a stable run of DBNC cycles
`include "gop_regs.svh"
module gop_debounce #(
    parameter int N = 16,
    parameter int DBNC = `GOP_DBNC_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [N-1:0] raw,
    gop_sync_if.src out
);
    import gop_pkg::*;
    initial begin
        if (N != GOP_NIN || DBNC < 2 || DBNC > 255) $error("bad debounce params");
    end
    logic [N-1:0] s1_q, s2_q, lvl_q, rise_q;
    logic [7:0] cnt_q [N];
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
        end
    end
    for (genvar i = 0; i < N; i++) begin : g_b
        wire differs = s2_q[i] != lvl_q[i];
        wire done = cnt_q[i] == 8'(DBNC - 1);
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                cnt_q[i] <= 8'h00;
                lvl_q[i] <= 1'b0;
                rise_q[i] <= 1'b0;
            end else begin
                cnt_q[i] <= (differs && !done) ? cnt_q[i] + 8'h01 : 8'h00;
                lvl_q[i] <= (differs && done) ? s2_q[i] : lvl_q[i];
                rise_q[i] <= differs && done && s2_q[i];
            end
        end
    end
    assign out.lvl = lvl_q;
    assign out.rise = rise_q;
endmodule

// ---- src/gop_apb.sv ----
// Purpose: apb slave holding configuration and showing block state
// Assumes: zero wait state answers
// Notes: unmapped addresses read zero and raise pslverr
`include "gop_regs.svh"
module gop_apb (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [7:0] cfg,
    output logic [7:0] sw_cmd,
    input wire logic [31:0] stat,
    input wire logic [7:0] disp,
    input wire logic [15:0] runt
);
    logic [7:0] cfg_q, cmd_q;
    wire acc = psel && penable;
    wire hit_ctrl = paddr == `GOP_OFF_CTRL;
    wire hit_cfg = paddr == `GOP_OFF_CFG;
    wire hit_stat = paddr == `GOP_OFF_STAT;
    wire hit_disp = paddr == `GOP_OFF_DISP;
    wire hit_runt = paddr == `GOP_OFF_RUNT;
    wire hit = hit_ctrl | hit_cfg | hit_stat | hit_disp | hit_runt;
    wire [31:0] rd = hit_cfg ? {24'h000000, cfg_q} : hit_stat ? stat :
        hit_disp ? {24'h000000, disp} : hit_runt ? {16'h0000, runt} : 32'h00000000;
    assign pready = 1'b1;
    assign pslverr = acc && !hit;
    assign prdata = rd;
    assign cfg = cfg_q;
    assign sw_cmd = cmd_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cfg_q <= 8'h00;
            cmd_q <= 8'h00;
        end else begin
            cmd_q <= (acc && pwrite && hit_ctrl) ? pwdata[7:0] : 8'h00;
            if (acc && pwrite && hit_cfg) cfg_q <= pwdata[7:0];
        end
    end
endmodule

// ---- verification/gop_gate_model.sv ----
// Purpose: gate travel model driving the two limit contacts
// Assumes: one position step per clock while a motor runs
// Notes: short travel keeps runs brief
module gop_gate_model #(
    parameter int TRAV = 200
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic motor_open,
    input wire logic motor_close,
    output logic lim_open,
    output logic lim_close
);
    timeunit 1ns;
    timeprecision 1ps;
    int pos_q;
    // both commands at once would be a driver fault: open wins below the open limit, no masking
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pos_q <= 0;
        end else if (motor_open && pos_q < TRAV) begin
            pos_q <= pos_q + 1;
        end else if (motor_close && pos_q > 0) begin
            pos_q <= pos_q - 1;
        end
    end
    assign lim_open = (pos_q == TRAV);
    assign lim_close = (pos_q == 0);
endmodule

// ---- verification/tb_top.sv ----
// Purpose: self-checking bench for the gate operator core
// Assumes: seconds shortened to 1000 cycles, short reverse
// Notes: gate starts fully closed
`include "gop_regs.svh"
module tb_top;
    import gop_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rstn, link_ok, psel, penable, pwrite;
    logic [15:0] drv;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, er, mo, mc, beeper, lim_o, lim_c;
    logic bg, ag, mm, mf, lled, mled;
    logic [7:0] disp;
    int error_cnt = 0;
    int num_checks = 0;
    gop_gate_model gm_u (.clk(clk), .rstn(rstn), .motor_open(mo), .motor_close(mc),
        .lim_open(lim_o), .lim_close(lim_c));
    // drv[12] masks the open limit to model a stuck switch
    gop_core #(.CLK_HZ(1000), .REV_CYC(50), .MAXRUN_S(1)) dut_u (.clk(clk), .rstn(rstn),
        .raw_in({drv[15:14], lim_c, lim_o & ~drv[12], drv[11:0]}), .link_ok(link_ok),
        .batt_good(bg), .ac_good(ag), .motor_mismatch(mm), .motor_fail(mf),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .motor_open(mo),
        .motor_close(mc), .disp_code(disp), .beeper(beeper), .link_led(lled),
        .maxrun_led(mled));
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // hold the access until pready is seen at an edge
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic press(input int b);
        drv[b] <= 1'b1;
        repeat (30) @(posedge clk);
        drv[b] <= 1'b0;
        repeat (30) @(posedge clk);
    endtask
    // count rising edges of beeper (sel 0) or link_led (sel 1) over n cycles
    task automatic rises(input int n, input bit sel, output int r);
        logic p, v;
        r = 0;
        p = sel ? lled : beeper;
        repeat (n) begin
            @(posedge clk);
            v = sel ? lled : beeper;
            if (v && !p) r++;
            p = v;
        end
    endtask
    // bounded wait, then compare the motor pair {open, close}
    task automatic wmot(input logic [1:0] e);
        int n;
        n = 0;
        while ({mo, mc} !== e && n < 3000) begin
            @(posedge clk);
            n++;
        end
        chk({30'h0, e}, {30'h0, mo, mc});
    endtask
    task automatic t_powerup;
        chk({24'h0, `GOP_CODE_DASH}, {24'h0, disp});
        repeat (1500) @(posedge clk);
        chk({24'h0, `GOP_CODE_VER}, {24'h0, disp});
        repeat (700) @(posedge clk);
        $display("done powerup");
    endtask
    task automatic t_regs;
        apb(1'b0, `GOP_OFF_CFG, 32'h0);
        chk(32'h0, rd);
        apb(1'b1, `GOP_OFF_CFG, 32'h0000000A);
        apb(1'b0, `GOP_OFF_CFG, 32'h0);
        chk(32'h0000000A, rd);
        apb(1'b1, `GOP_OFF_CFG, 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        chk({31'h0, 1'b1}, {31'h0, er});
        chk(32'h0, rd);
        $display("done regs");
    endtask
    task automatic t_open_stop;
        press(9);
        wmot(2'b10);
        press(2);
        wmot(2'b00);
        chk({24'h0, `GOP_CODE_STOP}, {24'h0, disp});
        $display("done open_stop");
    endtask
    task automatic t_obstruct;
        press(0);
        wmot(2'b10);
        repeat (20) @(posedge clk);
        drv[5] <= 1'b1;
        wmot(2'b01);
        drv[5] <= 1'b0;
        wmot(2'b00);
        press(14);
        wmot(2'b10);
        repeat (20) @(posedge clk);
        drv[5] <= 1'b1;
        wmot(2'b00);
        drv[5] <= 1'b0;
        repeat (30) @(posedge clk);
        chk({24'h0, `GOP_CODE_ENT}, {24'h0, disp});
        chk(32'h1, {31'h0, beeper});
        press(2);
        chk(32'h0, {31'h0, beeper});
        $display("done obstruct");
    endtask
    task automatic t_emergency;
        press(4);
        wmot(2'b10);
        wmot(2'b00);
        // display is registered one edge behind the lock state
        repeat (2) @(posedge clk);
        wmot(2'b00);
        chk({24'h0, `GOP_CODE_EMRG}, {24'h0, disp});
        apb(1'b0, `GOP_OFF_STAT, 32'h0);
        chk({28'h0, GOP_LOCK_EMRG}, {28'h0, rd[3:0]});
        wmot(2'b00);
        press(2);
        apb(1'b0, `GOP_OFF_STAT, 32'h0);
        chk({28'h0, GOP_IDLE}, {28'h0, rd[3:0]});
        $display("done emergency");
    endtask
    task automatic t_close_rev;
        press(1);
        wmot(2'b01);
        press(0);
        wmot(2'b10);
        press(1);
        wmot(2'b01);
        press(2);
        wmot(2'b00);
        press(11);
        repeat (100) @(posedge clk);
        wmot(2'b00);
        $display("done close_rev");
    endtask
    task automatic t_fault;
        bg <= 1'b0;
        repeat (4) @(posedge clk);
        chk({24'h0, `GOP_CODE_PWR}, {24'h0, disp});
        {bg, mm} <= 2'b11;
        repeat (4) @(posedge clk);
        chk({24'h0, `GOP_CODE_MIS}, {24'h0, disp});
        mf <= 1'b1;
        repeat (4) @(posedge clk);
        chk({24'h0, `GOP_CODE_MFL}, {24'h0, disp});
        {ag, mm, mf} <= 3'b000;
        repeat (4) @(posedge clk);
        chk({24'h0, `GOP_CODE_ACL}, {24'h0, disp});
        ag <= 1'b1;
        repeat (4) @(posedge clk);
        apb(1'b0, `GOP_OFF_STAT, 32'h0);
        chk({28'h0, GOP_IDLE}, {28'h0, rd[3:0]});
        $display("done fault");
    endtask
    task automatic t_maxrun;
        int r;
        drv[12] <= 1'b1;
        press(0);
        wmot(2'b00);
        repeat (2) @(posedge clk);
        chk({24'h0, `GOP_CODE_RUNO}, {24'h0, disp});
        chk(32'h1, {31'h0, mled});
        chk(32'h1, {31'h0, beeper});
        press(2);
        drv[12] <= 1'b0;
        rises(5000, 1'b0, r);
        chk(32'h2, r);
        press(1);
        wmot(2'b01);
        chk(32'h0, {31'h0, mled});
        press(2);
        wmot(2'b00);
        $display("done maxrun");
    endtask
    task automatic t_link;
        int r;
        apb(1'b1, `GOP_OFF_CFG, 32'h00000008);
        link_ok <= 1'b0;
        repeat (50) @(posedge clk);
        press(0);
        wmot(2'b00);
        chk({24'h0, `GOP_CODE_LINK}, {24'h0, disp});
        rises(1000, 1'b1, r);
        chk(32'h1, r);
        chk(32'h1, {31'h0, beeper});
        $display("done link");
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        rstn = 1'b0;
        link_ok = 1'b1;
        {bg, ag, mm, mf} = 4'b1100;
        drv = 16'h0000;
        {psel, penable, pwrite} = 3'b000;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        t_powerup();
        t_regs();
        t_open_stop();
        t_obstruct();
        t_emergency();
        t_close_rev();
        t_fault();
        t_maxrun();
        t_link();
        end_of_test();
    end
    // whole run needs well under 15k cycles
    initial begin
        #(8ns * 40000);
        error_cnt++;
        end_of_test();
    end
endmodule
